// ===== hdl/csp_regs.vh
// Register indices, field positions, reset values and timing counts for the cyclic position block.
`ifndef CSP_REGS_VH
`define CSP_REGS_VH
`define CSP_IDX_CMD 16'h6040
`define CSP_IDX_STATE 16'h6041
`define CSP_IDX_TGT 16'h607a
`define CSP_IDX_POS_OFS 16'h60b0
`define CSP_IDX_VEL_OFS 16'h60b1
`define CSP_IDX_TRQ_OFS 16'h60b2
`define CSP_IDX_MODE 16'h6060
`define CSP_IDX_FE_WIN 16'h6065
`define CSP_IDX_FE_TMO 16'h6066
`define CSP_IDX_IP_PER 16'h60c2
`define CSP_IDX_XTO 16'h2f75
`define CSP_IDX_VLIM 16'h6080
`define CSP_IDX_TLIM 16'h6072
`define CSP_IDX_POS_ACT 16'h6064
`define CSP_CMD_SO 0
`define CSP_CMD_EV 1
`define CSP_CMD_QS 2
`define CSP_CMD_EO 3
`define CSP_CMD_FR 7
`define CSP_CMD_HALT 8
`define CSP_ST_RTSO 0
`define CSP_ST_SO 1
`define CSP_ST_OE 2
`define CSP_ST_FLT 3
`define CSP_ST_VE 4
`define CSP_ST_QS 5
`define CSP_ST_SOD 6
`define CSP_ST_WARN 7
`define CSP_ST_REM 9
`define CSP_ST_LIM 11
`define CSP_ST_FOLLOW 12
`define CSP_ST_FERR 13
`define CSP_RST_OFS 32'h00000000
`define CSP_RST_FE_WIN 32'h00001000
`define CSP_RST_FE_TMO 16'h000a
`define CSP_RST_IP_PER 16'h000a
`define CSP_RST_XTO 16'h0014
`define CSP_RST_VLIM 32'h00100000
`define CSP_RST_TLIM 16'h03e8
`define CSP_CLK_HZ 10000000
`define CSP_MS_TICK_CYC 10000
`define CSP_MS_TICK_LAST 14'h270f
`define CSP_KP_SHIFT 4
`define CSP_KV_SHIFT 6
`endif

// ===== hdl/csp_sat.v
// Signed symmetric clamp used for the speed and torque limits.
module csp_sat #(
   parameter W = 32
) (
   // Value and bound
   input wire signed [W-1:0] value,
   input wire [W-1:0] bound,
   // Result
   output reg signed [W-1:0] result,
   output reg clipped
);
   always @*
   begin
      result = value;
      clipped = 1'b0;
      if (value > $signed(bound))
      begin
         result = $signed(bound);
         clipped = 1'b1;
      end
      else if (value < -$signed(bound))
      begin
         result = -$signed(bound);
         clipped = 1'b1;
      end
   end
endmodule

// ===== hdl/csp_core.v
// Cyclic synchronous position block: object access, drive state, interpolation and cascaded loops.
//
// Function
// - Target position is absolute loop demand.
// - Interpolate between updates each interpolation period.
// - Position, velocity, torque loops run cascaded.
// - Always report actual position; others optional.
// - Following error, speed, torque limits, quick stop.
// - Error beyond window past timeout sets bit13.
// - Command bits: on, voltage, quickstop, enable, reset.
// - Halt stops interpolation, brings motor to rest.
// - Stop disables interpolation until operation re-enabled.
// - Missing target past timeout triggers quick stop.
// - Bit12 shows target used or ignored.
// - Status bits report drive state flags.
// - Bits 8, 14, 15 zero; bit 10 reserved.
// - Position offset signed 32-bit, default zero.
// - Position offset absolute, never accumulates.
// - Velocity offset signed 32-bit feedforward.
// - Torque offset signed 16-bit feedforward.
// - Torque offset absolute, added to torque.
`include "csp_regs.vh"
module csp_core (
   // Clock and reset
   input wire ref_clk,
   input wire rst,
   // Object access port
   input wire obj_wr,
   input wire obj_rd,
   input wire [15:0] obj_index,
   input wire [31:0] obj_wdata,
   output reg [31:0] obj_rdata,
   output reg obj_ack,
   output reg obj_err,
   // Cyclic timing and sensors
   input wire sync_pulse,
   input wire internal_fault,
   input wire signed [31:0] pos_actual_in,
   input wire signed [31:0] vel_actual_in,
   // Drive outputs
   output reg signed [15:0] torque_demand,
   output reg signed [31:0] pos_actual,
   output reg signed [31:0] vel_actual,
   output reg [15:0] drive_state_word
);
   // ----------------------------------------
   // Drive states
   // ----------------------------------------
   localparam ST_SOD = 6'b000001;
   localparam ST_RTSO = 6'b000010;
   localparam ST_SWON = 6'b000100;
   localparam ST_OPEN = 6'b001000;
   localparam ST_QSTOP = 6'b010000;
   localparam ST_FAULT = 6'b100000;

   reg [15:0] drive_command_word_reg, fe_timeout_reg, ip_period_reg, xto_reg, tlim_reg;
   reg [15:0] fe_cnt_reg, xto_cnt_reg, seg_ms_reg;
   reg signed [31:0] position_offset_reg, velocity_offset_reg, target_reg;
   reg signed [31:0] seg_start_reg, seg_end_reg, pos_dem_reg, interp_pos;
   reg signed [15:0] torque_offset_reg;
   reg [31:0] fe_window_reg, vlim_reg;
   reg [5:0] state_reg, state_next;
   reg ip_en_reg, halt_reg, tgt_new_reg, fe_flag_reg;
   reg fault_meta_reg, fault_sync_reg, sync_meta_reg, sync_sync_reg, sync_prev_reg;
   reg [13:0] tick_reg;
   wire [15:0] cw;
   wire ms_tick, sync_edge, vel_clip, trq_clip, stop_req;
   wire signed [31:0] abs_target, pos_err, vel_cmd, vel_lim, trq_raw, trq_lim;
   wire [31:0] pos_err_mag;

   assign cw = drive_command_word_reg;
   assign ms_tick = (tick_reg == `CSP_MS_TICK_LAST);
   assign sync_edge = sync_sync_reg & ~sync_prev_reg;

   // ----------------------------------------
   // Object writes and reads
   // ----------------------------------------
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         drive_command_word_reg <= 16'h0000;
         position_offset_reg <= `CSP_RST_OFS;
         velocity_offset_reg <= `CSP_RST_OFS;
         torque_offset_reg <= 16'h0000;
         target_reg <= 32'h00000000;
         fe_window_reg <= `CSP_RST_FE_WIN;
         fe_timeout_reg <= `CSP_RST_FE_TMO;
         ip_period_reg <= `CSP_RST_IP_PER;
         xto_reg <= `CSP_RST_XTO;
         vlim_reg <= `CSP_RST_VLIM;
         tlim_reg <= `CSP_RST_TLIM;
         tgt_new_reg <= 1'b0;
         obj_ack <= 1'b0;
         obj_err <= 1'b0;
         obj_rdata <= 32'h00000000;
      end
      else
      begin
         obj_ack <= obj_wr | obj_rd;
         obj_err <= 1'b0;
         obj_rdata <= 32'h00000000;
         tgt_new_reg <= 1'b0;
         if (obj_wr)
         begin
            case (obj_index)
               `CSP_IDX_CMD: drive_command_word_reg <= obj_wdata[15:0];
               `CSP_IDX_TGT:
               begin
                  target_reg <= obj_wdata;
                  tgt_new_reg <= 1'b1;
               end
               `CSP_IDX_POS_OFS: position_offset_reg <= obj_wdata;
               `CSP_IDX_VEL_OFS: velocity_offset_reg <= obj_wdata;
               `CSP_IDX_TRQ_OFS: torque_offset_reg <= obj_wdata[15:0];
               `CSP_IDX_FE_WIN: fe_window_reg <= obj_wdata;
               `CSP_IDX_FE_TMO: fe_timeout_reg <= obj_wdata[15:0];
               `CSP_IDX_IP_PER: ip_period_reg <= obj_wdata[15:0];
               `CSP_IDX_XTO: xto_reg <= obj_wdata[15:0];
               `CSP_IDX_VLIM: vlim_reg <= obj_wdata;
               `CSP_IDX_TLIM: tlim_reg <= obj_wdata[15:0];
               default: obj_err <= 1'b1;
            endcase
         end
         else if (obj_rd)
         begin
            case (obj_index)
               `CSP_IDX_CMD: obj_rdata <= {16'h0000, drive_command_word_reg};
               `CSP_IDX_STATE: obj_rdata <= {16'h0000, drive_state_word};
               `CSP_IDX_TGT: obj_rdata <= target_reg;
               `CSP_IDX_POS_OFS: obj_rdata <= position_offset_reg;
               `CSP_IDX_VEL_OFS: obj_rdata <= velocity_offset_reg;
               `CSP_IDX_TRQ_OFS: obj_rdata <= {{16{torque_offset_reg[15]}}, torque_offset_reg};
               `CSP_IDX_FE_WIN: obj_rdata <= fe_window_reg;
               `CSP_IDX_FE_TMO: obj_rdata <= {16'h0000, fe_timeout_reg};
               `CSP_IDX_IP_PER: obj_rdata <= {16'h0000, ip_period_reg};
               `CSP_IDX_XTO: obj_rdata <= {16'h0000, xto_reg};
               `CSP_IDX_VLIM: obj_rdata <= vlim_reg;
               `CSP_IDX_TLIM: obj_rdata <= {16'h0000, tlim_reg};
               `CSP_IDX_POS_ACT: obj_rdata <= pos_actual;
               default: obj_err <= 1'b1;
            endcase
         end
      end
   end

   // ----------------------------------------
   // Drive state machine
   // ----------------------------------------
   // Command bit decode
   always @*
   begin
      state_next = state_reg;
      case (state_reg)
         ST_SOD: if (cw[`CSP_CMD_EV] & cw[`CSP_CMD_QS] & ~cw[`CSP_CMD_SO]) state_next = ST_RTSO;
         ST_RTSO:
         begin
            if (~cw[`CSP_CMD_EV])
               state_next = ST_SOD;
            else if (cw[`CSP_CMD_SO] & cw[`CSP_CMD_QS])
               state_next = ST_SWON;
         end
         ST_SWON:
         begin
            if (~cw[`CSP_CMD_EV] | ~cw[`CSP_CMD_QS])
               state_next = ST_SOD;
            else if (~cw[`CSP_CMD_SO])
               state_next = ST_RTSO;
            else if (cw[`CSP_CMD_EO])
               state_next = ST_OPEN;
         end
         ST_OPEN:
         begin
            if (~cw[`CSP_CMD_EV])
               state_next = ST_SOD;
            else if (~cw[`CSP_CMD_QS])
               state_next = ST_QSTOP;
            else if (~cw[`CSP_CMD_SO])
               state_next = ST_RTSO;
            else if (~cw[`CSP_CMD_EO])
               state_next = ST_SWON;
         end
         ST_QSTOP: if (~cw[`CSP_CMD_EV] | (vel_actual == 32'sd0 && cw[`CSP_CMD_QS] == 1'b0)) state_next = ST_SOD;
         ST_FAULT: if (cw[`CSP_CMD_FR] & ~fault_sync_reg) state_next = ST_SOD;
         default: state_next = ST_SOD;
      endcase
      if (fault_sync_reg)
         state_next = ST_FAULT;
      else if (state_reg == ST_OPEN && ip_en_reg && xto_cnt_reg >= xto_reg)
         state_next = ST_QSTOP;
   end

   assign stop_req = (state_reg != ST_OPEN) | (state_next != ST_OPEN);

   // ----------------------------------------
   // Interpolation enable and timers
   // ----------------------------------------
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         state_reg <= ST_SOD;
         ip_en_reg <= 1'b0;
         halt_reg <= 1'b0;
         xto_cnt_reg <= 16'h0000;
         fault_meta_reg <= 1'b0;
         fault_sync_reg <= 1'b0;
         sync_meta_reg <= 1'b0;
         sync_sync_reg <= 1'b0;
         sync_prev_reg <= 1'b0;
         tick_reg <= 14'h0000;
      end
      else
      begin
         state_reg <= state_next;
         halt_reg <= cw[`CSP_CMD_HALT];
         fault_meta_reg <= internal_fault;
         fault_sync_reg <= fault_meta_reg;
         sync_meta_reg <= sync_pulse;
         sync_sync_reg <= sync_meta_reg;
         sync_prev_reg <= sync_sync_reg;
         tick_reg <= (ms_tick | sync_edge) ? 14'h0000 : tick_reg + 14'h0001;
         if (stop_req)
            ip_en_reg <= 1'b0;
         else if (!ip_en_reg)
            ip_en_reg <= 1'b1;
         if (!ip_en_reg || halt_reg || tgt_new_reg)
            xto_cnt_reg <= 16'h0000;
         else if (ms_tick && xto_cnt_reg != 16'hffff)
            xto_cnt_reg <= xto_cnt_reg + 16'h0001;
      end
   end

   assign abs_target = target_reg + position_offset_reg;

   always @*
   begin
      interp_pos = seg_end_reg;
      if (seg_ms_reg < ip_period_reg && ip_period_reg != 16'h0000)
         interp_pos = seg_start_reg + (seg_end_reg - seg_start_reg) / $signed({16'h0000, ip_period_reg})
                      * $signed({16'h0000, seg_ms_reg});
   end

   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         seg_start_reg <= 32'h00000000;
         seg_end_reg <= 32'h00000000;
         seg_ms_reg <= 16'h0000;
         pos_dem_reg <= 32'h00000000;
      end
      else if (!ip_en_reg || halt_reg)
      begin
         // Holding the actual position keeps the loop quiet while stopped.
         seg_start_reg <= pos_actual_in;
         seg_end_reg <= pos_actual_in;
         seg_ms_reg <= 16'h0000;
         pos_dem_reg <= pos_actual_in;
      end
      else
      begin
         if (tgt_new_reg)
         begin
            seg_start_reg <= pos_dem_reg;
            seg_end_reg <= abs_target;
            seg_ms_reg <= 16'h0000;
         end
         else if (ms_tick && seg_ms_reg != 16'hffff)
            seg_ms_reg <= seg_ms_reg + 16'h0001;
         pos_dem_reg <= interp_pos;
      end
   end

   // ----------------------------------------
   // Cascaded loops and limits
   // ----------------------------------------
   assign pos_err = pos_dem_reg - pos_actual_in;
   assign pos_err_mag = pos_err[31] ? 32'h00000000 - pos_err : pos_err;
   assign vel_cmd = (pos_err >>> `CSP_KP_SHIFT) + velocity_offset_reg;
   csp_sat #(.W(32)) u_vsat (
      .value(vel_cmd),
      .bound(vlim_reg),
      .result(vel_lim),
      .clipped(vel_clip)
   );
   assign trq_raw = ((vel_lim - vel_actual_in) >>> `CSP_KV_SHIFT) + {{16{torque_offset_reg[15]}}, torque_offset_reg};
   csp_sat #(.W(32)) u_tsat (
      .value(trq_raw),
      .bound({16'h0000, tlim_reg}),
      .result(trq_lim),
      .clipped(trq_clip)
   );

   // ----------------------------------------
   // Following error and outputs
   // ----------------------------------------
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         fe_cnt_reg <= 16'h0000;
         fe_flag_reg <= 1'b0;
         torque_demand <= 16'h0000;
         pos_actual <= 32'h00000000;
         vel_actual <= 32'h00000000;
         drive_state_word <= 16'h0000;
      end
      else
      begin
         if (!ip_en_reg || pos_err_mag <= fe_window_reg)
         begin
            fe_cnt_reg <= 16'h0000;
            fe_flag_reg <= 1'b0;
         end
         else
         begin
            if (ms_tick && fe_cnt_reg != 16'hffff)
               fe_cnt_reg <= fe_cnt_reg + 16'h0001;
            if (fe_cnt_reg >= fe_timeout_reg)
               fe_flag_reg <= 1'b1;
         end
         torque_demand <= (state_reg == ST_OPEN || state_reg == ST_QSTOP) ? trq_lim[15:0] : 16'h0000;
         pos_actual <= pos_actual_in;
         vel_actual <= vel_actual_in;
         drive_state_word <= 16'h0000;
         drive_state_word[`CSP_ST_RTSO] <= (state_reg & (ST_RTSO | ST_SWON | ST_OPEN | ST_QSTOP)) != 6'b000000;
         drive_state_word[`CSP_ST_SO] <= (state_reg & (ST_SWON | ST_OPEN | ST_QSTOP)) != 6'b000000;
         drive_state_word[`CSP_ST_OE] <= (state_reg & (ST_OPEN | ST_QSTOP)) != 6'b000000;
         drive_state_word[`CSP_ST_FLT] <= state_reg == ST_FAULT;
         drive_state_word[`CSP_ST_VE] <= cw[`CSP_CMD_EV];
         drive_state_word[`CSP_ST_QS] <= state_reg != ST_QSTOP;
         drive_state_word[`CSP_ST_SOD] <= state_reg == ST_SOD;
         drive_state_word[`CSP_ST_WARN] <= fe_cnt_reg != 16'h0000;
         drive_state_word[`CSP_ST_REM] <= 1'b1;
         drive_state_word[`CSP_ST_LIM] <= vel_clip | trq_clip;
         drive_state_word[`CSP_ST_FOLLOW] <= ip_en_reg & ~halt_reg;
         drive_state_word[`CSP_ST_FERR] <= fe_flag_reg;
      end
   end
endmodule

// ===== test/csp_core_properties.sv
// Port-level assertions for the cyclic position block.
module csp_core_chk (
   // Clock and reset
   input wire ref_clk,
   input wire rst,
   // Object access port
   input wire obj_wr,
   input wire obj_rd,
   input wire [15:0] obj_index,
   input wire [31:0] obj_wdata,
   input wire [31:0] obj_rdata,
   input wire obj_ack,
   input wire obj_err,
   // Drive side
   input wire sync_pulse,
   input wire internal_fault,
   input wire signed [31:0] pos_actual_in,
   input wire signed [31:0] vel_actual_in,
   input wire signed [15:0] torque_demand,
   input wire signed [31:0] pos_actual,
   input wire signed [31:0] vel_actual,
   input wire [15:0] drive_state_word
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence req_s;
      obj_wr || obj_rd;
   endsequence
   sequence halt_s;
      obj_wr && obj_index == 16'h6040 && obj_wdata[8];
   endsequence
   a_ack_follows_req: assert property (req_s |=> obj_ack)
      else $error("no acknowledge after request");
   a_ack_has_cause: assert property (obj_ack && !$past(rst) |-> $past(obj_wr || obj_rd))
      else $error("acknowledge without request");
   a_err_with_ack: assert property (obj_err |-> obj_ack)
      else $error("error without acknowledge");
   a_known_no_err: assert property (obj_rd && !obj_wr && obj_index == 16'h60b0 |=> !obj_err)
      else $error("error on a mapped read");
   a_reserved_zero: assert property (drive_state_word[8] == 1'b0 && drive_state_word[15:14] == 2'b00)
      else $error("reserved status bits set");
   a_follow_enabled: assert property (drive_state_word[12] |-> drive_state_word[2])
      else $error("following while not enabled");
   a_halt_stops: assert property (halt_s |-> ##[1:3] !drive_state_word[12])
      else $error("halt did not stop following");
   a_fault_no_torque: assert property (drive_state_word[3] && $past(drive_state_word[3]) |-> torque_demand == 16'sh0)
      else $error("torque while in fault");
   a_pos_copy: assert property (!$past(rst) |-> pos_actual == $past(pos_actual_in))
      else $error("actual position not reported");
   a_vel_copy: assert property (!$past(rst) |-> vel_actual == $past(vel_actual_in))
      else $error("actual velocity not reported");
   a_sod_after_reset: assert property ($fell(rst) |-> ##[0:2] drive_state_word[6])
      else $error("not switch-on-disabled after reset");
endmodule

// ===== test/csp_ctl_model.sv
// Controller-side model: sync pulses and sensor feedback.
module csp_ctl_model #(
   parameter int PERIOD = 10000
) (
   // Clock and reset
   input wire ref_clk,
   input wire rst,
   // Bench control
   input wire signed [31:0] pos_set,
   // Towards the drive
   output logic sync_pulse = 1'b0,
   output logic signed [31:0] pos_actual_in = 32'sh0,
   output logic signed [31:0] vel_actual_in = 32'sh0
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt = 0;
   // periodic sync
   // A pulse of several cycles, so the synchroniser cannot miss it.
   always @(posedge ref_clk)
   begin
      cnt <= (rst || cnt == PERIOD - 1) ? 0 : cnt + 1;
      sync_pulse <= !rst && cnt < 4;
      pos_actual_in <= pos_set;
      // Velocity is the position change per clock, so it settles to zero.
      vel_actual_in <= pos_set - pos_actual_in;
   end
endmodule

// ===== test/testbench.sv
// Self-checking bench for the cyclic position block.
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk, rst, obj_wr, obj_rd, internal_fault, obj_ack, obj_err, sync_pulse;
   logic [15:0] obj_index, drive_state_word;
   logic [31:0] obj_wdata, obj_rdata, rd_v;
   logic signed [31:0] pos_set, pos_actual_in, vel_actual_in, pos_actual, vel_actual;
   logic signed [15:0] torque_demand;
   logic [15:0] ti [3] = '{16'h60b0, 16'h60b1, 16'h60b2};
   logic [31:0] tw [3] = '{32'h80000001, 32'h7fffffff, 32'h00008000};
   logic [31:0] te [3] = '{32'h80000001, 32'h7fffffff, 32'hffff8000};
   int mismatches = 0;
   int n_checks = 0;
   int cyc = 0;
   csp_core csp_core_i (.ref_clk, .rst, .obj_wr, .obj_rd, .obj_index, .obj_wdata, .obj_rdata, .obj_ack,
      .obj_err, .sync_pulse, .internal_fault, .pos_actual_in, .vel_actual_in, .torque_demand, .pos_actual,
      .vel_actual, .drive_state_word);
   csp_ctl_model csp_ctl_model_i (.ref_clk, .rst, .pos_set, .sync_pulse, .pos_actual_in, .vel_actual_in);
   initial
   begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   // The whole run needs about 64000 cycles.
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 95000)
      begin
         mismatches++;
         conclude();
      end
   end
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m, input string s);
      n_checks++;
      if ((got & m) !== (exp & m))
         begin
         mismatches++;
         $display("ERROR t=%0t %s got %h exp %h", $time, s, got, exp);
         end
   endtask
   task automatic acc(input logic w, input logic [15:0] i, input logic [31:0] d, input logic e);
      @(posedge ref_clk);
      #1 {obj_wr, obj_rd, obj_index, obj_wdata} = {w, !w, i, d};
      @(posedge ref_clk);
      #1 {obj_wr, obj_rd} = 2'b00;
      rd_v = obj_rdata;
      chk({obj_ack, obj_err}, {1'b1, e}, 32'h3, "ack/err");
   endtask
   task automatic waitc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic feed(input int n, input logic [31:0] t);
      repeat (n)
      begin
         acc(1'b1, 16'h607a, t, 1'b0);
         waitc(1000);
      end
   endtask
   task automatic enable();
      acc(1'b1, 16'h607a, pos_set, 1'b0);
      acc(1'b1, 16'h6040, 32'h0006, 1'b0);
      waitc(3);
      chk(drive_state_word, 32'h0021, 32'h006f, "ready");
      acc(1'b1, 16'h6040, 32'h0007, 1'b0);
      waitc(3);
      chk(drive_state_word, 32'h0023, 32'h006f, "switched on");
      acc(1'b1, 16'h6040, 32'h000f, 1'b0);
      waitc(3);
      chk(drive_state_word, 32'h1027, 32'h106f, "enabled");
   endtask
   initial
   begin
      {rst, obj_wr, obj_rd, obj_index, obj_wdata, internal_fault, pos_set} = {3'b100, 81'h0};
      repeat (10) @(posedge ref_clk);
      #1 rst = 1'b0;
      waitc(2);
      chk(drive_state_word, 32'h0240, 32'hf34f, "reset status");
      for (int k = 0; k < 3; k++)
      begin
         acc(1'b0, ti[k], 32'h0, 1'b0);
         chk(rd_v, 32'h0, 32'hffffffff, "offset default");
      end
      $display("test reset done");
      // Each offset is written twice; the second write must not add up.
      for (int k = 0; k < 3; k++)
      begin
         acc(1'b1, ti[k], tw[k], 1'b0);
         acc(1'b1, ti[k], tw[k], 1'b0);
         acc(1'b0, ti[k], 32'h0, 1'b0);
         chk(rd_v, te[k], 32'hffffffff, "offset readback");
         acc(1'b1, ti[k], 32'h0, 1'b0);
      end
      acc(1'b1, 16'h6041, 32'h1, 1'b1);
      acc(1'b0, 16'h1234, 32'h0, 1'b1);
      $display("test objects done");
      enable();
      acc(1'b1, 16'h6040, 32'h010f, 1'b0);
      waitc(3);
      chk(drive_state_word, 32'h0, 32'h1000, "halt");
      acc(1'b1, 16'h6040, 32'h000f, 1'b0);
      waitc(3);
      chk(drive_state_word, 32'h1000, 32'h1000, "halt released");
      $display("test halt done");
      acc(1'b1, 16'h2f75, 32'h1, 1'b0);
      waitc(12000);
      chk(drive_state_word, 32'h0, 32'h1020, "target lost");
      acc(1'b1, 16'h2f75, 32'h14, 1'b0);
      acc(1'b1, 16'h6040, 32'h0002, 1'b0);
      waitc(3);
      enable();
      $display("test extrapolation done");
      acc(1'b1, 16'h6065, 32'h10, 1'b0);
      acc(1'b1, 16'h6066, 32'h1, 1'b0);
      acc(1'b1, 16'h60c2, 32'h1, 1'b0);
      feed(30, 32'h4000);
      chk({31'h0, torque_demand > 0}, 32'h1, 32'h1, "loop drive");
      chk(drive_state_word, 32'h2000, 32'h2000, "error set");
      pos_set = 32'sh4000;
      feed(10, 32'h4000);
      chk(drive_state_word, 32'h0, 32'h2000, "error clear");
      chk(32'(torque_demand), 32'h0, 32'hffff, "at rest");
      acc(1'b1, 16'h60b2, 32'd100, 1'b0);
      acc(1'b1, 16'h60b2, 32'd100, 1'b0);
      waitc(4);
      chk(32'(torque_demand), 32'd100, 32'hffff, "torque feedforward");
      acc(1'b1, 16'h60b2, 32'h0, 1'b0);
      acc(1'b1, 16'h60b0, 32'h4000, 1'b0);
      feed(12, 32'h4000);
      chk({31'h0, torque_demand > 0}, 32'h1, 32'h1, "position offset");
      acc(1'b1, 16'h60b0, 32'h0, 1'b0);
      $display("test loops done");
      internal_fault = 1'b1;
      waitc(6);
      chk(drive_state_word, 32'h0008, 32'h104f, "fault");
      internal_fault = 1'b0;
      waitc(4);
      acc(1'b1, 16'h6040, 32'h0080, 1'b0);
      waitc(3);
      chk(drive_state_word, 32'h0040, 32'h004f, "fault reset");
      $display("test fault done");
      conclude();
   end
endmodule
bind csp_core csp_core_chk csp_core_chk_i (.ref_clk, .rst, .obj_wr, .obj_rd, .obj_index, .obj_wdata, .obj_rdata,
   .obj_ack, .obj_err, .sync_pulse, .internal_fault, .pos_actual_in, .vel_actual_in, .torque_demand, .pos_actual,
   .vel_actual, .drive_state_word);
